// >>> sram_host.sv
`timescale 1ns/1ns
`default_nettype none
module sram_host
    import sram_host_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    // user side
    input wire logic req_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    input wire logic [LANES-1:0] req_lanes_in,
    output logic busy_out,
    output logic done_out,
    output logic [DATA_W-1:0] rdata_out,
    output logic density_ok_out,
    // memory pins
    output logic [ADDR_W-1:0] addr_out,
    output logic write_n_out,
    output logic oe_n_out,
    output logic [LANES-1:0] byte_select_n_out,
    output logic [DATA_W-1:0] data_bus_out,
    output logic data_bus_oe_out,
    input wire logic [DATA_W-1:0] data_bus_in,
    input wire logic [1:0] density_id_pins_in
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [DATA_W-1:0] data_sync;
    logic [1:0] id_sync;
    sync3 #(.WIDTH(DATA_W)) u_data_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .async_in(data_bus_in),
        .sync_out(data_sync)
    );
    sync3 #(.WIDTH(2)) u_id_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .async_in(density_id_pins_in),
        .sync_out(id_sync)
    );

    // ****************************************************************
    // sequencer
    // ****************************************************************
    host_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic we_n_q, we_n_d, oe_n_q, oe_n_d;
    logic [LANES-1:0] sel_n_q, sel_n_d;
    logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic drive_q, drive_d, busy_q, busy_d, done_q, done_d, id_q, id_d;

    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q == CNT_ZERO) ? CNT_ZERO : cnt_q - 4'h1;
        addr_d = addr_q;
        we_n_d = we_n_q;
        oe_n_d = oe_n_q;
        sel_n_d = sel_n_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        drive_d = drive_q;
        busy_d = busy_q;
        done_d = 1'b0;
        id_d = (id_sync == DENSITY_CODE);
        unique case (state_q)
            ST_IDLE: begin
                busy_d = 1'b0;
                if (req_in) begin
                    busy_d = 1'b1;
                    addr_d = req_addr_in;
                    sel_n_d = ~req_lanes_in;
                    wdata_d = req_wdata_in;
                    if (req_write_in) begin
                        // oe held high so the shorter pulse applies
                        oe_n_d = 1'b1;
                        state_d = ST_WSET;
                        cnt_d = 4'(CYC_TURN);
                    end else begin
                        we_n_d = 1'b1;
                        oe_n_d = 1'b0;
                        state_d = ST_READ;
                        // count covers access time and sync delay
                        cnt_d = 4'(CYC_ACCESS + 3);
                    end
                end
            end
            ST_READ: begin
                if (cnt_q == CNT_ZERO) begin
                    // unselected lanes float, read as zero here
                    for (int i = 0; i < LANES; i++) begin
                        rdata_d[i*8 +: 8] = sel_n_q[i] ? 8'h00
                            : data_sync[i*8 +: 8];
                    end
                    oe_n_d = 1'b1;
                    sel_n_d = {LANES{1'b1}};
                    done_d = 1'b1;
                    state_d = ST_TURN;
                    cnt_d = 4'(CYC_TURN);
                end
            end
            ST_WSET: begin
                // device may still drive; wait its float time
                if (cnt_q == CNT_ZERO) begin
                    we_n_d = 1'b0;
                    drive_d = 1'b1;
                    state_d = ST_WPULSE;
                    cnt_d = 4'(CYC_WP);
                end
            end
            ST_WPULSE: begin
                if (cnt_q == CNT_ZERO) begin
                    // select and strobe rise together: outputs stay off
                    we_n_d = 1'b1;
                    sel_n_d = {LANES{1'b1}};
                    state_d = ST_WREC;
                    cnt_d = CNT_ZERO;
                end
            end
            ST_WREC: begin
                drive_d = 1'b0;
                done_d = 1'b1;
                state_d = ST_TURN;
                cnt_d = 4'(CYC_CYCLE);
            end
            ST_TURN: begin
                if (cnt_q == CNT_ZERO) begin
                    busy_d = 1'b0;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_ZERO;
            addr_q <= '0;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            sel_n_q <= {LANES{1'b1}};
            wdata_q <= '0;
            rdata_q <= '0;
            drive_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            id_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            we_n_q <= we_n_d;
            oe_n_q <= oe_n_d;
            sel_n_q <= sel_n_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            drive_q <= drive_d;
            busy_q <= busy_d;
            done_q <= done_d;
            id_q <= id_d;
        end
    end

    assign addr_out = addr_q;
    assign write_n_out = we_n_q;
    assign oe_n_out = oe_n_q;
    assign byte_select_n_out = sel_n_q;
    assign data_bus_out = wdata_q;
    assign data_bus_oe_out = drive_q;
    assign busy_out = busy_q;
    assign done_out = done_q;
    assign rdata_out = rdata_q;
    assign density_ok_out = id_q;
endmodule : sram_host
`default_nettype wire

// >>> sram_host_pkg.sv
// ****************************************************************
// Operation
// - keep write strobe high during every read cycle.
// - any subset of byte selects may be asserted; timing treats them as one.
// - output enable is a don't care while write strobe is low.
// - write pulse may be shorter while output enable stays high.
// - cycle measured address valid to address change, minimum 15 ns.
// - with select and output enable held, new data follows address.
// - in select-controlled write, hold select for enable-to-end time.
// ****************************************************************
package sram_host_pkg;
    localparam int CLK_NS = 20;
    // timing figures in ns, fast grade
    localparam int T_CYCLE_NS = 15;
    localparam int T_ACCESS_NS = 15;
    localparam int T_WP_NS = 12;
    localparam int T_WP_GHIGH_NS = 10;
    localparam int T_DW_NS = 7;
    localparam int T_OHZ_NS = 8;
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up
    localparam int CYC_CYCLE = cyc_up(T_CYCLE_NS);
    localparam int CYC_ACCESS = cyc_up(T_ACCESS_NS) + 1;
    localparam int CYC_WP = cyc_up(T_WP_GHIGH_NS);
    localparam int CYC_TURN = cyc_up(T_OHZ_NS);
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam logic [1:0] DENSITY_CODE = 2'h1;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_WSET = 3'b010,
        ST_WPULSE = 3'b011,
        ST_WREC = 3'b100,
        ST_TURN = 3'b101
    } host_state_t;
endpackage : sram_host_pkg

// >>> sync3.sv
`timescale 1ns/1ns
`default_nettype none
module sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] async_in,
    output var logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
    logic [WIDTH-1:0] out_d;
    always_comb begin
        // settled only once second and third agree
        for (int i = 0; i < WIDTH; i++) begin
            out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
        end
    end
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end
    assign sync_out = out_q;
endmodule : sync3
`default_nettype wire

// >>> sram_model.sv
`timescale 1ns/1ns
`default_nettype none
module sram_model (
    input wire logic clk_in,
    input wire logic [15:0] addr_in,
    input wire logic write_n_in,
    input wire logic oe_n_in,
    input wire logic [3:0] sel_n_in,
    input wire logic [31:0] host_data_in,
    input wire logic host_oe_in,
    output logic [31:0] data_out,
    output logic [1:0] density_out
);
    logic [31:0] mem [0:65535];
    // known start so a floating bus really toggles instead of staying unknown
    logic [31:0] last_q = 32'h0;
    assign density_out = 2'h1;
    // floating lanes toggle so a stale value never reads as good data
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!oe_n_in && write_n_in && !sel_n_in[i]) begin
                data_out[8*i +: 8] = mem[addr_in][8*i +: 8];
            end else if (host_oe_in) begin
                data_out[8*i +: 8] = host_data_in[8*i +: 8];
            end else begin
                data_out[8*i +: 8] = ~last_q[8*i +: 8];
            end
        end
    end
    always @(posedge clk_in) begin
        last_q <= data_out;
        for (int i = 0; i < 4; i++) begin
            if (!write_n_in && !sel_n_in[i]) begin
                mem[addr_in][8*i +: 8] <= data_out[8*i +: 8];
            end
        end
    end
endmodule : sram_model
`default_nettype wire

// >>> sram_host_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module sram_host_checker
    import sram_host_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic req_in,
    input wire logic req_write_in,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic write_n_out,
    input wire logic oe_n_out,
    input wire logic [LANES-1:0] byte_select_n_out,
    input wire logic data_bus_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    read_wr_high_a: assert property (!oe_n_out |-> write_n_out)
        else $error("write strobe low during read");
    write_overlap_a: assert property (!write_n_out |-> byte_select_n_out != 4'hF)
        else $error("write strobe without select");
    write_drive_a: assert property (!write_n_out |-> data_bus_oe_out && oe_n_out)
        else $error("bus not driven in write");
    no_contend_a: assert property (!oe_n_out |-> !data_bus_oe_out)
        else $error("host drives during read");
    pulse_len_a: assert property ($fell(write_n_out) |=> !write_n_out ##1 write_n_out)
        else $error("write pulse length wrong");
    sel_end_a: assert property ($rose(write_n_out) |-> byte_select_n_out == 4'hF)
        else $error("select held past strobe");
    sel_first_a: assert property ($fell(write_n_out) |-> $past(byte_select_n_out) != 4'hF)
        else $error("select late for write");
    read_lat_a: assert property (req_in && !busy_out && !req_write_in |-> ##7 done_out)
        else $error("read answer late");
    write_lat_a: assert property (req_in && !busy_out && req_write_in |-> ##6 done_out)
        else $error("write answer late");
    done_once_a: assert property (done_out |=> !done_out && busy_out)
        else $error("done not a single pulse");
endmodule : sram_host_checker
`default_nettype wire

// >>> tb_sram_host.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sram_host;
    import sram_host_pkg::*;
    logic clk_in = 1'b0, reset_in = 1'b1, req_in = 1'b0, req_write_in = 1'b0;
    logic [15:0] req_addr_in = 16'h0, addr_out;
    logic [31:0] req_wdata_in = 32'h0, rdata_out, data_bus_out, q;
    logic [3:0] req_lanes_in = 4'h0, byte_select_n_out;
    logic busy_out, done_out, density_ok_out, write_n_out, oe_n_out;
    logic data_bus_oe_out;
    wire logic [31:0] data_bus_in;
    wire logic [1:0] density_id_pins_in;
    int errors = 0, tests_run = 0;
    always #10 clk_in = ~clk_in;
    sram_host dut (.clk_in(clk_in), .reset_in(reset_in), .req_in(req_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .req_lanes_in(req_lanes_in),
        .busy_out(busy_out), .done_out(done_out), .rdata_out(rdata_out),
        .density_ok_out(density_ok_out), .addr_out(addr_out),
        .write_n_out(write_n_out), .oe_n_out(oe_n_out),
        .byte_select_n_out(byte_select_n_out), .data_bus_out(data_bus_out),
        .data_bus_oe_out(data_bus_oe_out), .data_bus_in(data_bus_in),
        .density_id_pins_in(density_id_pins_in));
    sram_model mem (.clk_in(clk_in), .addr_in(addr_out),
        .write_n_in(write_n_out), .oe_n_in(oe_n_out),
        .sel_n_in(byte_select_n_out), .host_data_in(data_bus_out),
        .host_oe_in(data_bus_oe_out), .data_out(data_bus_in),
        .density_out(density_id_pins_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    // ****************************************************************
    // transfers
    // ****************************************************************
    task automatic finish_op();
        int n;
        n = 0;
        do @(negedge clk_in); while (done_out !== 1'b1 && ++n < 20);
        q = rdata_out;
        check({31'h0, done_out}, 32'h1);
        n = 0;
        while (busy_out !== 1'b0 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        check({31'h0, busy_out}, 32'h0);
    endtask : finish_op
    task automatic do_op(input logic wr, input logic [15:0] a,
        input logic [31:0] d, input logic [3:0] m);
        @(posedge clk_in);
        req_in <= 1'b1;
        req_write_in <= wr;
        req_addr_in <= a;
        req_wdata_in <= d;
        req_lanes_in <= m;
        @(posedge clk_in);
        req_in <= 1'b0;
        finish_op();
    endtask : do_op
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_full();
        do_op(1'b1, 16'h0000, 32'h12345678, 4'hF);
        do_op(1'b1, 16'hFFFF, 32'h9ABCDEF0, 4'hF);
        do_op(1'b0, 16'h0000, 32'h0, 4'hF);
        check(q, 32'h12345678);
        do_op(1'b0, 16'hFFFF, 32'h0, 4'hF);
        check(q, 32'h9ABCDEF0);
        check({31'h0, density_ok_out}, 32'h1);
    endtask : test_full
    task automatic test_lanes();
        do_op(1'b1, 16'h0100, 32'hFFFFFFFF, 4'hF);
        for (int i = 0; i < 4; i++) begin
            do_op(1'b1, 16'h0100, 32'h0, 4'h1 << i);
            do_op(1'b0, 16'h0100, 32'h0, 4'hF);
            check(q, 32'hFFFFFFFF << (8 * (i + 1)));
        end
        do_op(1'b1, 16'h0100, 32'hA1B2C3D4, 4'hF);
        for (int i = 0; i < 4; i++) begin
            do_op(1'b0, 16'h0100, 32'h0, 4'h1 << i);
            check(q, 32'hA1B2C3D4 & (32'hFF << (8 * i)));
        end
    endtask : test_lanes
    task automatic test_refused();
        do_op(1'b1, 16'h0010, 32'h00000001, 4'hF);
        @(posedge clk_in);
        req_in <= 1'b1;
        req_addr_in <= 16'h0020;
        req_wdata_in <= 32'h00000002;
        @(posedge clk_in);
        req_addr_in <= 16'h0010;
        req_wdata_in <= 32'h00000003;
        @(posedge clk_in);
        req_in <= 1'b0;
        finish_op();
        do_op(1'b0, 16'h0010, 32'h0, 4'hF);
        check(q, 32'h00000001);
        do_op(1'b0, 16'h0020, 32'h0, 4'hF);
        check(q, 32'h00000002);
    endtask : test_refused
    initial begin
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        test_full();
        test_lanes();
        test_refused();
        stop_test();
    end
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule : tb_sram_host
bind sram_host sram_host_checker chk (.clk_in(clk_in), .reset_in(reset_in),
    .req_in(req_in), .req_write_in(req_write_in), .busy_out(busy_out),
    .done_out(done_out), .write_n_out(write_n_out), .oe_n_out(oe_n_out),
    .byte_select_n_out(byte_select_n_out), .data_bus_oe_out(data_bus_oe_out));
`default_nettype wire
